// file: logic/ltg_pkg.sv
// Package of timing constants for the command timing guard.
// Assumes a single 125 MHz clock shared with the memory command path.
// Notes on behaviour
// - After power-down exit no command goes out before max(2 cycles, 7.5 ns).
// - A precharge waits max(2 cycles, 7.5 ns) after a read to the same bank.
// - A bank activate waits 3 cycles and 15 or 18 ns after that bank's precharge.
// - After an all-bank precharge activates wait 15/18 ns (four banks) or 18/21 ns (eight).
// - A read waits 2 cycles and 7.5 ns after a write, 10 ns at the slow rates.
// - Activates to two different banks are max(2 cycles, 10 ns) apart.
// - Deep power-down is held at least 500 us before exit starts.
// - When the temperature register flags derating, core row limits gain a margin.
// - Each limit uses the longer of its cycle count and its time.
// - Cycle minimums bind only when the clock period exceeds 6 ns, except the fixed column and mode spacings.
// - Accesses should be spread across rows to protect device lifetime.
// - Mode writes are 5 cycles apart and mode reads 2 cycles apart.
package ltg_pkg;
	localparam int CLK_PS         = 8000;
	localparam int LONG_PERIOD_PS = 6000;
	localparam int NBANK          = 8;
	localparam int CW             = 8;
	localparam int DPW            = 17;
	localparam int XP_PS          = 7500;
	localparam int RTP_PS         = 7500;
	localparam int RCD_FAST_PS    = 15000;
	localparam int RCD_TYP_PS     = 18000;
	localparam int RPPB_FAST_PS   = 15000;
	localparam int RPPB_TYP_PS    = 18000;
	localparam int RPAB4_FAST_PS  = 15000;
	localparam int RPAB4_TYP_PS   = 18000;
	localparam int RPAB8_FAST_PS  = 18000;
	localparam int RPAB8_TYP_PS   = 21000;
	localparam int RAS_MIN_PS     = 42000;
	localparam int RAS_MAX_NS     = 70000;
	localparam int WR_PS          = 15000;
	localparam int WTR_PS         = 7500;
	localparam int WTR_SLOW_PS    = 10000;
	localparam int RRD_PS         = 10000;
	localparam int FAW_PS         = 50000;
	localparam int FAW_SLOW_PS    = 60000;
	localparam int DPD_US         = 500;
	localparam int DERATE_PS      = 1875;
	localparam int XP_CK          = 2;
	localparam int RTP_CK         = 2;
	localparam int RCD_CK         = 3;
	localparam int RP_CK          = 3;
	localparam int RAS_CK         = 3;
	localparam int WR_CK          = 3;
	localparam int WTR_CK         = 2;
	localparam int RRD_CK         = 2;
	localparam int FAW_CK         = 8;
	localparam int CCD_CK         = 2;
	localparam int MRW_CK         = 5;
	localparam int MRR_CK         = 2;
	localparam int DPD_CYCLES     = DPD_US * 1000000 / CLK_PS;
	localparam int RAS_MAX_CYCLES = RAS_MAX_NS * 1000 / CLK_PS;
	localparam logic [7:0] TEMP_MR_ADDR = 8'h04;
	localparam logic [2:0] CMD_NOP  = 3'h0;
	localparam logic [2:0] CMD_ACT  = 3'h1;
	localparam logic [2:0] CMD_RD   = 3'h2;
	localparam logic [2:0] CMD_WR   = 3'h3;
	localparam logic [2:0] CMD_PRE  = 3'h4;
	localparam logic [2:0] CMD_PREA = 3'h5;
	localparam logic [2:0] CMD_MRW  = 3'h6;
	localparam logic [2:0] CMD_MRR  = 3'h7;

	// Rounded-up cycles of a time, floored by a cycle minimum when that minimum binds
	function automatic logic [CW-1:0] ltg_cyc(input int ps, input int ck);
		int c;
		c = (ps + CLK_PS - 1) / CLK_PS;
		if ((CLK_PS > LONG_PERIOD_PS) && (ck > c))
			c = ck;
		if (c < 1)
			c = 1;
		return CW'(c);
	endfunction : ltg_cyc
endpackage : ltg_pkg

// file: logic/ltg_down_counter.sv
// Loadable down-counter that reports when its wait has run out.
// Assumes the loader presents the full wait length on value_in while pulsing load_in.
module ltg_down_counter
	import ltg_pkg::*;
#(
	parameter int W = CW
)(
	input  wire logic         ref_clk_in,
	input  wire logic         rst_in,
	input  wire logic         load_in,
	input  wire logic [W-1:0] value_in,
	output logic              done_out
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;

	always_comb
	begin
		cnt_next = cnt_reg;
		if (load_in)
			cnt_next = value_in;
		else if (cnt_reg != '0)
			cnt_next = cnt_reg - W'(1);
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_next;
	end

	assign done_out = (cnt_reg <= W'(1));
endmodule : ltg_down_counter

// file: logic/ltg_guard.sv
// Command timing guard between the command issuer and the memory die.
// Assumes one request at a time and that the die obeys the sent commands.
module ltg_guard
	import ltg_pkg::*;
#(
	parameter bit FAST_GRADE   = 1'b1,
	parameter bit EIGHT_BANK   = 1'b1,
	parameter bit SLOW_RATE    = 1'b0,
	parameter int DPD_WAIT     = DPD_CYCLES,
	parameter int RAS_MAX_WAIT = RAS_MAX_CYCLES
)(
	input  wire logic       ref_clk_in,
	input  wire logic       rst_in,
	input  wire logic       req_valid_in,
	input  wire logic [2:0] req_cmd_in,
	input  wire logic [2:0] req_bank_in,
	input  wire logic [7:0] req_mr_addr_in,
	input  wire logic [7:0] req_mr_data_in,
	input  wire logic       pd_exit_in,
	input  wire logic       dpd_enter_in,
	input  wire logic       dpd_exit_req_in,
	input  wire logic       temp_derate_in,
	output logic            req_ready_out,
	output logic            cmd_valid_out,
	output logic [2:0]      cmd_out,
	output logic [2:0]      cmd_bank_out,
	output logic [7:0]      cmd_mr_addr_out,
	output logic [7:0]      cmd_mr_data_out,
	output logic            dpd_exit_ok_out,
	output logic            ras_max_due_out,
	output logic            derate_active_out
);
	typedef enum logic [1:0] {LTG_RUN, LTG_DPD} ltg_state_t;

	localparam int RCD_PS  = FAST_GRADE ? RCD_FAST_PS : RCD_TYP_PS;
	localparam int RPPB_PS = FAST_GRADE ? RPPB_FAST_PS : RPPB_TYP_PS;
	localparam int RPAB_PS = EIGHT_BANK ? (FAST_GRADE ? RPAB8_FAST_PS : RPAB8_TYP_PS)
		: (FAST_GRADE ? RPAB4_FAST_PS : RPAB4_TYP_PS);
	localparam int WTRX_PS = SLOW_RATE ? WTR_SLOW_PS : WTR_PS;
	localparam int FAWX_PS = SLOW_RATE ? FAW_SLOW_PS : FAW_PS;
	localparam logic [CW-1:0] XP_C   = ltg_cyc(XP_PS, XP_CK);
	localparam logic [CW-1:0] RTP_C  = ltg_cyc(RTP_PS, RTP_CK);
	localparam logic [CW-1:0] WR_C   = ltg_cyc(WR_PS, WR_CK);
	localparam logic [CW-1:0] WTR_C  = ltg_cyc(WTRX_PS, WTR_CK);
	localparam logic [CW-1:0] FAW_C  = ltg_cyc(FAWX_PS, FAW_CK);
	localparam logic [CW-1:0] CCD_C  = CW'(CCD_CK);
	localparam logic [CW-1:0] MRW_C  = CW'(MRW_CK);
	localparam logic [CW-1:0] MRR_C  = CW'(MRR_CK);
	localparam logic [CW-1:0] RCD_N  = ltg_cyc(RCD_PS, RCD_CK);
	localparam logic [CW-1:0] RCD_D  = ltg_cyc(RCD_PS + DERATE_PS, RCD_CK);
	localparam logic [CW-1:0] RPB_N  = ltg_cyc(RPPB_PS, RP_CK);
	localparam logic [CW-1:0] RPB_D  = ltg_cyc(RPPB_PS + DERATE_PS, RP_CK);
	localparam logic [CW-1:0] RPA_N  = ltg_cyc(RPAB_PS, RP_CK);
	localparam logic [CW-1:0] RPA_D  = ltg_cyc(RPAB_PS + DERATE_PS, RP_CK);
	localparam logic [CW-1:0] RAS_N  = ltg_cyc(RAS_MIN_PS, RAS_CK);
	localparam logic [CW-1:0] RAS_D  = ltg_cyc(RAS_MIN_PS + DERATE_PS, RAS_CK);
	localparam logic [CW-1:0] RRD_N  = ltg_cyc(RRD_PS, RRD_CK);
	localparam logic [CW-1:0] RRD_D  = ltg_cyc(RRD_PS + DERATE_PS, RRD_CK);

	ltg_state_t   state_reg;
	ltg_state_t   state_next;
	logic [DPW:0] dpd_cnt_reg;
	logic [DPW:0] dpd_cnt_next;
	logic [DPW:0] ras_max_cnt_reg [NBANK];
	logic [DPW:0] ras_max_cnt_next [NBANK];
	logic         derate_reg;
	logic         derate_next;
	logic         cmd_valid_reg;
	logic         cmd_valid_next;
	logic [2:0]   cmd_reg;
	logic [2:0]   cmd_next;
	logic [2:0]   bank_reg;
	logic [2:0]   bank_next;
	logic [7:0]   mra_reg;
	logic [7:0]   mra_next;
	logic [7:0]   mrd_reg;
	logic [7:0]   mrd_next;

	logic [NBANK-1:0] act_ld;
	logic [NBANK-1:0] pre_ld;
	logic [NBANK-1:0] rtp_ld;
	logic [NBANK-1:0] wr_ld;
	logic [NBANK-1:0] ras_ld;
	logic [NBANK-1:0] rcd_ok;
	logic [NBANK-1:0] rp_ok;
	logic [NBANK-1:0] rtp_ok;
	logic [NBANK-1:0] wr_ok;
	logic [NBANK-1:0] ras_ok;
	logic [CW-1:0]    rp_val;
	logic             xp_ok;
	logic             wtr_ok;
	logic             rrd_ok;
	logic             ccd_ok;
	logic             mrw_ok;
	logic             mrr_ok;
	logic [3:0]       faw_ok;
	logic [1:0]       faw_ptr_reg;
	logic [1:0]       faw_ptr_next;
	logic [3:0]       faw_ld;
	logic             go;
	logic             allowed;
	logic             is_act;
	logic             is_col;

	assign is_act = req_cmd_in == CMD_ACT;
	assign is_col = (req_cmd_in == CMD_RD) || (req_cmd_in == CMD_WR);
	assign rp_val = (req_cmd_in == CMD_PREA) ? (derate_reg ? RPA_D : RPA_N)
		: (derate_reg ? RPB_D : RPB_N);

	always_comb
	begin
		allowed = xp_ok;
		case (req_cmd_in)
			CMD_ACT:  allowed = allowed && rp_ok[req_bank_in] && rrd_ok && faw_ok[faw_ptr_reg];
			CMD_RD:   allowed = allowed && rcd_ok[req_bank_in] && wtr_ok && ccd_ok;
			CMD_WR:   allowed = allowed && rcd_ok[req_bank_in] && ccd_ok;
			CMD_PRE:  allowed = allowed && rtp_ok[req_bank_in] && wr_ok[req_bank_in]
				&& ras_ok[req_bank_in];
			CMD_PREA: allowed = allowed && (&rtp_ok) && (&wr_ok) && (&ras_ok);
			CMD_MRW:  allowed = allowed && mrw_ok && mrr_ok;
			CMD_MRR:  allowed = allowed && mrr_ok && mrw_ok;
			default:  allowed = allowed;
		endcase
	end

	assign req_ready_out = (state_reg == LTG_RUN) && allowed;
	assign go = req_valid_in && req_ready_out && (req_cmd_in != CMD_NOP);

	always_comb
	begin
		for (int b = 0; b < NBANK; b++)
		begin
			act_ld[b] = go && is_act && (req_bank_in == 3'(b));
			ras_ld[b] = act_ld[b];
			pre_ld[b] = go && ((req_cmd_in == CMD_PREA)
				|| (req_cmd_in == CMD_PRE && req_bank_in == 3'(b)));
			rtp_ld[b] = go && req_cmd_in == CMD_RD && req_bank_in == 3'(b);
			wr_ld[b]  = go && req_cmd_in == CMD_WR && req_bank_in == 3'(b);
		end
		faw_ld = '0;
		if (go && is_act)
			faw_ld[faw_ptr_reg] = 1'b1;
	end

	for (genvar b = 0; b < NBANK; b++)
	begin : g_bank
		ltg_down_counter u_rcd (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .load_in(act_ld[b]),
			.value_in(derate_reg ? RCD_D : RCD_N), .done_out(rcd_ok[b]));
		ltg_down_counter u_rp (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .load_in(pre_ld[b]),
			.value_in(rp_val), .done_out(rp_ok[b]));
		ltg_down_counter u_rtp (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .load_in(rtp_ld[b]),
			.value_in(RTP_C), .done_out(rtp_ok[b]));
		ltg_down_counter u_wr (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .load_in(wr_ld[b]),
			.value_in(WR_C), .done_out(wr_ok[b]));
		ltg_down_counter u_ras (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .load_in(ras_ld[b]),
			.value_in(derate_reg ? RAS_D : RAS_N), .done_out(ras_ok[b]));
	end

	for (genvar f = 0; f < 4; f++)
	begin : g_faw
		ltg_down_counter u_faw (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .load_in(faw_ld[f]),
			.value_in(FAW_C), .done_out(faw_ok[f]));
	end

	ltg_down_counter u_xp (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.load_in    (pd_exit_in),
		.value_in   (XP_C),
		.done_out   (xp_ok)
	);
	ltg_down_counter u_wtr (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.load_in    (go && req_cmd_in == CMD_WR),
		.value_in   (WTR_C),
		.done_out   (wtr_ok)
	);
	ltg_down_counter u_rrd (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.load_in    (go && is_act),
		.value_in   (derate_reg ? RRD_D : RRD_N),
		.done_out   (rrd_ok)
	);
	ltg_down_counter u_ccd (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.load_in    (go && is_col),
		.value_in   (CCD_C),
		.done_out   (ccd_ok)
	);
	ltg_down_counter u_mrw (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.load_in    (go && req_cmd_in == CMD_MRW),
		.value_in   (MRW_C),
		.done_out   (mrw_ok)
	);
	ltg_down_counter u_mrr (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.load_in    (go && req_cmd_in == CMD_MRR),
		.value_in   (MRR_C),
		.done_out   (mrr_ok)
	);

	// Deep power-down residency and command register
	always_comb
	begin
		state_next     = state_reg;
		dpd_cnt_next   = dpd_cnt_reg;
		derate_next    = derate_reg;
		faw_ptr_next   = faw_ptr_reg;
		cmd_valid_next = go;
		cmd_next       = cmd_reg;
		bank_next      = bank_reg;
		mra_next       = mra_reg;
		mrd_next       = mrd_reg;
		if (go)
		begin
			cmd_next  = req_cmd_in;
			bank_next = req_bank_in;
			mra_next  = req_mr_addr_in;
			mrd_next  = req_mr_data_in;
		end
		if (go && is_act)
			faw_ptr_next = faw_ptr_reg + 2'h1;
		if (temp_derate_in)
			derate_next = 1'b1;
		else if (go && req_cmd_in == CMD_MRR && req_mr_addr_in == TEMP_MR_ADDR)
			derate_next = 1'b0;
		case (state_reg)
			LTG_RUN:
			begin
				if (dpd_enter_in)
				begin
					state_next   = LTG_DPD;
					dpd_cnt_next = (DPW+1)'(DPD_WAIT);
				end
			end
			LTG_DPD:
			begin
				if (dpd_cnt_reg != '0)
					dpd_cnt_next = dpd_cnt_reg - (DPW+1)'(1);
				else if (dpd_exit_req_in)
					state_next = LTG_RUN;
			end
			default: state_next = LTG_RUN;
		endcase
		for (int b = 0; b < NBANK; b++)
		begin
			if (ras_ld[b])
				ras_max_cnt_next[b] = (DPW+1)'(RAS_MAX_WAIT);
			else if (pre_ld[b])
				ras_max_cnt_next[b] = '0;
			else if (ras_max_cnt_reg[b] > (DPW+1)'(1))
				ras_max_cnt_next[b] = ras_max_cnt_reg[b] - (DPW+1)'(1);
			else
				ras_max_cnt_next[b] = ras_max_cnt_reg[b];
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			state_reg     <= LTG_RUN;
			dpd_cnt_reg   <= '0;
			derate_reg    <= 1'b0;
			faw_ptr_reg   <= 2'h0;
			cmd_valid_reg <= 1'b0;
			cmd_reg       <= CMD_NOP;
			bank_reg      <= 3'h0;
			mra_reg       <= 8'h00;
			mrd_reg       <= 8'h00;
			for (int b = 0; b < NBANK; b++)
				ras_max_cnt_reg[b] <= '0;
		end
		else
		begin
			state_reg     <= state_next;
			dpd_cnt_reg   <= dpd_cnt_next;
			derate_reg    <= derate_next;
			faw_ptr_reg   <= faw_ptr_next;
			cmd_valid_reg <= cmd_valid_next;
			cmd_reg       <= cmd_next;
			bank_reg      <= bank_next;
			mra_reg       <= mra_next;
			mrd_reg       <= mrd_next;
			for (int b = 0; b < NBANK; b++)
				ras_max_cnt_reg[b] <= ras_max_cnt_next[b];
		end
	end

	always_comb
	begin
		ras_max_due_out = 1'b0;
		for (int b = 0; b < NBANK; b++)
			if (ras_max_cnt_reg[b] == (DPW+1)'(1))
				ras_max_due_out = 1'b1;
	end

	assign cmd_valid_out     = cmd_valid_reg;
	assign cmd_out           = cmd_reg;
	assign cmd_bank_out      = bank_reg;
	assign cmd_mr_addr_out   = mra_reg;
	assign cmd_mr_data_out   = mrd_reg;
	assign dpd_exit_ok_out   = (state_reg == LTG_DPD) && (dpd_cnt_reg == '0);
	assign derate_active_out = derate_reg;
endmodule : ltg_guard

// file: bench/ltg_guard_monitor.sv
// Spacing checks on the timing guard's command outputs.
// Assumes the fast-grade, eight-bank, 8 ns settings of the package.
module ltg_guard_monitor
	import ltg_pkg::*;
#(
	parameter int DPD_WAIT = DPD_CYCLES
)(
	input wire logic       ref_clk_in,
	input wire logic       rst_in,
	input wire logic       req_valid_in,
	input wire logic [2:0] req_cmd_in,
	input wire logic [2:0] req_bank_in,
	input wire logic [7:0] req_mr_addr_in,
	input wire logic [7:0] req_mr_data_in,
	input wire logic       pd_exit_in,
	input wire logic       dpd_enter_in,
	input wire logic       dpd_exit_req_in,
	input wire logic       temp_derate_in,
	input wire logic       req_ready_out,
	input wire logic       cmd_valid_out,
	input wire logic [2:0] cmd_out,
	input wire logic [2:0] cmd_bank_out,
	input wire logic [7:0] cmd_mr_addr_out,
	input wire logic [7:0] cmd_mr_data_out,
	input wire logic       dpd_exit_ok_out,
	input wire logic       ras_max_due_out,
	input wire logic       derate_active_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        act;
	logic        pre;
	logic [17:0] dpd_cnt_reg;
	logic [17:0] dpd_cnt_next;
	logic [6:0]  act_hist_reg;
	logic [6:0]  act_hist_next;
	assign act = cmd_valid_out && cmd_out == CMD_ACT;
	assign pre = cmd_valid_out && cmd_out == CMD_PRE;
	// Cycles since deep sleep entry and recent activates
	always_comb
	begin
		act_hist_next = {act_hist_reg[5:0], act};
		dpd_cnt_next = dpd_cnt_reg;
		if (dpd_enter_in)
			dpd_cnt_next = 18'h0;
		else if (~&dpd_cnt_reg)
			dpd_cnt_next = dpd_cnt_reg + 18'h1;
	end
	always_ff @(posedge ref_clk_in)
	begin
		dpd_cnt_reg  <= rst_in ? 18'h0 : dpd_cnt_next;
		act_hist_reg <= rst_in ? 7'h0 : act_hist_next;
	end
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	sequence s_pd_hold;
		!req_ready_out ##1 !cmd_valid_out;
	endsequence
	sequence s_no_act_bank;
		!(act && cmd_bank_out == $past(cmd_bank_out)) ##1 !(act && cmd_bank_out == $past(cmd_bank_out, 2));
	endsequence
	property p_take;
		req_valid_in && req_ready_out && req_cmd_in != CMD_NOP |=> cmd_valid_out && cmd_out == $past(req_cmd_in);
	endproperty
	a_take: assert property (p_take) else $error("request not issued");
	property p_pdx;
		pd_exit_in |=> s_pd_hold;
	endproperty
	a_pdx: assert property (p_pdx) else $error("early command after power-down exit");
	property p_rd_pre;
		cmd_valid_out && cmd_out == CMD_RD |=> !(pre && cmd_bank_out == $past(cmd_bank_out));
	endproperty
	a_rd_pre: assert property (p_rd_pre) else $error("early precharge after read");
	property p_pre_act;
		pre |=> s_no_act_bank;
	endproperty
	a_pre_act: assert property (p_pre_act) else $error("early activate after precharge");
	property p_prea_act;
		cmd_valid_out && cmd_out == CMD_PREA |=> !act [*2];
	endproperty
	a_prea_act: assert property (p_prea_act) else $error("early activate after all-bank");
	property p_wr_rd;
		cmd_valid_out && cmd_out == CMD_WR |=> !(cmd_valid_out && cmd_out == CMD_RD);
	endproperty
	a_wr_rd: assert property (p_wr_rd) else $error("early read after write");
	property p_rrd;
		act |=> !(act && cmd_bank_out != $past(cmd_bank_out));
	endproperty
	a_rrd: assert property (p_rrd) else $error("activates too close");
	property p_dpd;
		dpd_exit_ok_out |-> dpd_cnt_reg >= 18'(DPD_WAIT);
	endproperty
	a_dpd: assert property (p_dpd) else $error("deep sleep exit too soon");
	property p_derate;
		temp_derate_in |=> derate_active_out;
	endproperty
	a_derate: assert property (p_derate) else $error("derate flag not set");
	property p_mrw;
		cmd_valid_out && cmd_out == CMD_MRW |=> !(cmd_valid_out && cmd_out == CMD_MRW) [*4];
	endproperty
	a_mrw: assert property (p_mrw) else $error("mode writes too close");
	property p_faw;
		act |-> $countones(act_hist_reg) <= 3;
	endproperty
	a_faw: assert property (p_faw) else $error("too many activates in window");
endmodule : ltg_guard_monitor

bind ltg_guard ltg_guard_monitor #(.DPD_WAIT(DPD_WAIT)) ltg_guard_monitor_inst (.*);

// file: bench/ltg_die_model.sv
// Behavioural mode register store of the memory die.
// Assumes commands arrive as one-cycle valid pulses from the guard.
module ltg_die_model
	import ltg_pkg::*;
#(
	parameter logic [7:0] RESET_MR_ADDR = 8'h3f,
	parameter logic [7:0] MR_DEFAULT    = 8'h00
)(
	input  wire logic       ref_clk_in,
	input  wire logic       cmd_valid_in,
	input  wire logic [2:0] cmd_in,
	input  wire logic [7:0] mr_addr_in,
	input  wire logic [7:0] mr_data_in,
	output logic      [7:0] rd_data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mr_reg [0:255];
	always @(posedge ref_clk_in)
	begin
		if (cmd_valid_in && cmd_in == CMD_MRW && mr_addr_in == RESET_MR_ADDR)
			for (int i = 0; i < 4; i++)
				mr_reg[i] <= MR_DEFAULT;
		else if (cmd_valid_in && cmd_in == CMD_MRW)
			mr_reg[mr_addr_in] <= mr_data_in;
		if (cmd_valid_in && cmd_in == CMD_MRR)
			rd_data_out <= mr_reg[mr_addr_in];
	end
endmodule : ltg_die_model

// file: bench/lpddr2_command_timing_guard_tb.sv
// Self-checking bench for the command timing guard with a die model.
// Assumes package constants; deep sleep residency is shortened to 20 and the row-open limit to 30.
module lpddr2_command_timing_guard_tb
	import ltg_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int         DPD_SIM = 20;
	localparam int         RAS_SIM = 30;
	localparam logic [7:0] RST_MR  = 8'h3f;
	logic       ref_clk_in, rst_in, req_valid_in, pd_exit_in, dpd_enter_in;
	logic       dpd_exit_req_in, temp_derate_in, req_ready_out, cmd_valid_out;
	logic       dpd_exit_ok_out, ras_max_due_out, derate_active_out;
	logic [2:0] req_cmd_in, req_bank_in, cmd_out, cmd_bank_out;
	logic [7:0] req_mr_addr_in, req_mr_data_in, cmd_mr_addr_out, cmd_mr_data_out;
	logic [7:0] rd_data, d;
	int         failures, checks, n;
	int         cyc = 0;
	int         last [0:7][0:7];
	ltg_guard #(.DPD_WAIT(DPD_SIM), .RAS_MAX_WAIT(RAS_SIM)) ltg_guard_inst (.*);
	ltg_die_model #(.RESET_MR_ADDR(RST_MR)) ltg_die_model_inst (
		.ref_clk_in   (ref_clk_in),
		.cmd_valid_in (cmd_valid_out),
		.cmd_in       (cmd_out),
		.mr_addr_in   (cmd_mr_addr_out),
		.mr_data_in   (cmd_mr_data_out),
		.rd_data_out  (rd_data)
	);
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic stop_test;
		if (failures == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test
	// Longer of rounded-up time and cycle floor
	function automatic int need(input int ps, input int ck);
		return ((ps + CLK_PS - 1) / CLK_PS > ck) ? (ps + CLK_PS - 1) / CLK_PS : ck;
	endfunction : need
	// Cycles required after command pc on bank pb before c on b
	function automatic int gap(input int pc, input int pb, input logic [2:0] c, input logic [2:0] b);
		case (pc)
			0: return need(XP_PS, XP_CK);
			CMD_PRE: return (c == CMD_ACT && pb == b) ? need(RPPB_FAST_PS, RP_CK) : 0;
			CMD_PREA: return (c == CMD_ACT) ? need(RPAB8_FAST_PS, RP_CK) : 0;
			CMD_RD: return (c == CMD_PRE && pb == b) ? need(RTP_PS, RTP_CK) : 0;
			CMD_WR: return (c == CMD_RD) ? need(WTR_PS, WTR_CK) : 0;
			CMD_ACT: return (c == CMD_ACT && pb != b) ? need(RRD_PS, RRD_CK) : 0;
			CMD_MRW: return (c == CMD_MRW) ? MRW_CK : 0;
			default: return (c == CMD_MRR) ? MRR_CK : 0;
		endcase
	endfunction : gap
	task automatic issue(input logic [2:0] c, input logic [2:0] b, input logic [7:0] a, input logic [7:0] v);
		int k;
		int t;
		k = 0;
		req_valid_in = 1'b1;
		req_cmd_in = c;
		req_bank_in = b;
		req_mr_addr_in = a;
		req_mr_data_in = v;
		#1;
		while (req_ready_out !== 1'b1 && k < 40)
		begin
			@(negedge ref_clk_in);
			#1;
			k++;
		end
		check("ready", k < 40, 1'b1);
		t = cyc + 1;
		foreach (last[p, q])
			check("spacing", t - last[p][q] >= gap(p, q, c, b), 1'b1);
		@(negedge ref_clk_in);
		check("issued", {cmd_valid_out, cmd_out, cmd_bank_out}, {1'b1, c, b});
		last[c][b] = t;
	endtask : issue
	task automatic pd_pulse;
		req_valid_in = 1'b0;
		pd_exit_in = 1'b1;
		last[0][0] = cyc + 1;
		@(negedge ref_clk_in);
		pd_exit_in = 1'b0;
	endtask : pd_pulse
	initial
	begin
		ref_clk_in = 1'b0;
		forever #4 ref_clk_in = ~ref_clk_in;
	end
	always @(posedge ref_clk_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			failures++;
			stop_test();
		end
	end
	initial
	begin
		{rst_in, req_valid_in, pd_exit_in, dpd_enter_in, dpd_exit_req_in, temp_derate_in} = 6'h20;
		{req_cmd_in, req_bank_in, req_mr_addr_in, req_mr_data_in} = 22'h0;
		failures = 0;
		checks = 0;
		foreach (last[p, q])
			last[p][q] = -1000;
		void'($urandom(32'h1a38));
		repeat (20) @(negedge ref_clk_in);
		rst_in = 1'b0;
		check("ready", req_ready_out, 1'b1);
		check("derate", derate_active_out, 1'b0);
		for (int c = 1; c < 8; c++)
			issue(3'(c), 3'h1, 8'h02, 8'h5a);
		pd_pulse();
		issue(CMD_PRE, 3'h1, 8'h00, 8'h00);
		issue(CMD_ACT, 3'h1, 8'h00, 8'h00);
		req_valid_in = 1'b0;
		repeat (RAS_SIM - 2) @(negedge ref_clk_in);
		check("row_open", ras_max_due_out, 1'b0);
		@(negedge ref_clk_in);
		check("row_open", ras_max_due_out, 1'b1);
		issue(CMD_PRE, 3'h1, 8'h00, 8'h00);
		check("row_open", ras_max_due_out, 1'b0);
		d = 8'($urandom);
		issue(CMD_MRW, 3'h0, 8'h01, d);
		issue(CMD_MRR, 3'h0, 8'h01, 8'h00);
		req_valid_in = 1'b0;
		@(negedge ref_clk_in);
		check("mode_read", rd_data, d);
		issue(CMD_MRW, 3'h0, RST_MR, 8'h00);
		issue(CMD_MRR, 3'h0, 8'h01, 8'h00);
		req_valid_in = 1'b0;
		temp_derate_in = 1'b1;
		@(negedge ref_clk_in);
		temp_derate_in = 1'b0;
		check("mode_default", rd_data, 8'h00);
		check("derate", derate_active_out, 1'b1);
		issue(CMD_MRR, 3'h0, TEMP_MR_ADDR, 8'h00);
		req_valid_in = 1'b0;
		dpd_enter_in = 1'b1;
		dpd_exit_req_in = 1'b1;
		@(negedge ref_clk_in);
		dpd_enter_in = 1'b0;
		check("derate", derate_active_out, 1'b0);
		n = 1;
		while (dpd_exit_ok_out !== 1'b1 && n < 100)
		begin
			check("dpd_ready", req_ready_out, 1'b0);
			@(negedge ref_clk_in);
			n++;
		end
		check("dpd_time", n >= DPD_SIM && n <= DPD_SIM + 2, 1'b1);
		repeat (2) @(negedge ref_clk_in);
		dpd_exit_req_in = 1'b0;
		for (int r = 0; r < 300; r++)
		begin
			if ($urandom % 8 == 0)
				pd_pulse();
			issue(3'(1 + $urandom % 7), 3'($urandom), 8'($urandom), 8'($urandom));
		end
		req_valid_in = 1'b0;
		stop_test();
	end
endmodule : lpddr2_command_timing_guard_tb
